// file: dv/ddr2_cmd_sva.sv
// assertions on the ports of the ddr2 command logic
`timescale 1ns/1ps
`default_nettype none
module ddr2_cmd_sva (
  // link clock and reset
  input wire logic        ck,
  input wire logic        reset,
  // command pins and latency
  input wire logic        cke,
  input wire logic        cs_n,
  input wire logic        ras_n,
  input wire logic        cas_n,
  input wire logic        we_n,
  input wire logic [2:0]  ba,
  input wire logic [13:0] addr,
  input wire logic        odt,
  input wire logic [2:0]  al,
  input wire logic        bl8,
  // link results
  input wire logic [1:0]  rtt_nom,
  input wire logic        odt_on,
  input wire logic [7:0]  bank_open,
  input wire logic [7:0]  pre_mask,
  input wire logic        self_refresh,
  input wire logic        issue_valid,
  input wire logic        issue_write,
  input wire logic [2:0]  issue_bank
);
  logic [4:0] quiet;
  logic [3:0] pins;
  logic       ok;
  default clocking @(posedge ck); endclocking
  default disable iff (reset);
  // edges since reset or self refresh, saturating
  always_ff @(posedge ck or posedge reset) begin
    if (reset) begin
      quiet <= 5'h00;
    end else if (self_refresh) begin
      quiet <= 5'h00;
    end else if (quiet != 5'h1f) begin
      quiet <= quiet + 5'h01;
    end
  end
  // pins in command order, valid only well clear of exit
  assign pins = {cs_n, ras_n, cas_n, we_n};
  assign ok = cke && quiet == 5'h1f;
  act_open_a: assert property (ok && pins == 4'h3 |->
    ##2 bank_open[$past(ba, 2)]) else $error("bank not opened");
  rd_issue_a: assert property (ok && pins == 4'h5 && al == 3'h0 |->
    ##2 issue_valid && !issue_write && issue_bank == $past(ba, 2))
    else $error("read not issued");
  wr_posted_a: assert property (ok && pins == 4'h4 && al == 3'h2 |->
    ##2 !issue_valid ##2 issue_valid && issue_write)
    else $error("posted write wrong");
  rd_ap_a: assert property (ok && pins == 4'h5 && addr[10] &&
    al == 3'h0 && !bl8 |-> ##4 pre_mask[$past(ba, 4)])
    else $error("read precharge late");
  prea_a: assert property (ok && pins == 4'h2 && addr[10] |->
    ##2 bank_open == 8'h00) else $error("banks left open");
  emr1_a: assert property (ok && pins == 4'h0 && ba == 3'h1 |->
    ##3 $stable(rtt_nom) ##1
    rtt_nom == {$past(addr[6], 4), $past(addr[2], 4)})
    else $error("termination update wrong");
  sre_a: assert property (quiet == 5'h1f && !cke && pins == 4'h1
    |-> ##2 self_refresh) else $error("self refresh not entered");
  sr_hold_a: assert property (self_refresh && !cke |=>
    self_refresh) else $error("self refresh left early");
  sr_mute_a: assert property (self_refresh |-> !issue_valid &&
    pre_mask == 8'h00 && !odt_on) else $error("activity in self refresh");
  odt_track_a: assert property (ok && !self_refresh |->
    ##2 odt_on == $past(odt, 2)) else $error("termination not followed");
endmodule
bind ddr2_command_function_logic ddr2_cmd_sva ddr2_cmd_sva_inst (.*);
`default_nettype wire

// file: dv/ddr2_ctrl_model.sv
// controller model driving the command pins on the link clock
`timescale 1ns/1ps
`default_nettype none
module ddr2_ctrl_model (
  // link clock
  input  wire logic        ck,
  // command pins
  output logic             cke,
  output logic             cs_n,
  output logic             ras_n,
  output logic             cas_n,
  output logic             we_n,
  output logic [2:0]       ba,
  output logic [13:0]      addr,
  output logic             odt
);
  // deselected and powered at time zero
  initial begin
    {cke, cs_n, ras_n, cas_n, we_n} = 5'h1f;
    ba = 3'h0;
    addr = 14'h0000;
    odt = 1'b0;
  end
  // one command for one edge, termination off for mode and refresh
  task automatic cmd(input logic [3:0] p, input logic [2:0] b,
                     input logic [13:0] a, input logic k);
    @(posedge ck);
    {cs_n, ras_n, cas_n, we_n} <= p;
    ba <= b;
    addr <= a;
    cke <= k;
    odt <= p[3:1] != 3'h0;
  endtask
  // deselect, released lines show a changing pattern
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge ck);
      cs_n <= 1'b1;
      ba <= ~ba;
      addr <= ~addr;
      odt <= 1'b0;
    end
  endtask
  // leave self refresh with deselect on the rising cke
  task automatic wake();
    @(posedge ck);
    cs_n <= 1'b1;
    cke <= 1'b1;
  endtask
endmodule
`default_nettype wire

// file: dv/tb_top.sv
// self-checking bench for the ddr2 command logic
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        ck = 1'b0;
  logic        ck_run = 1'b1;
  logic [2:0]  al = 3'h0;
  logic [2:0]  cl = 3'h3;
  logic [2:0]  wr = 3'h2;
  logic        bl8 = 1'b0;
  logic        cke, cs_n, ras_n, cas_n, we_n, odt, odt_on, self_refresh;
  logic        issue_valid, issue_write, refresh_pulse, dll_enable;
  logic [2:0]  ba, issue_bank;
  logic [13:0] addr, issue_row, refresh_row, r0;
  logic [9:0]  issue_col;
  logic [1:0]  rtt_nom;
  logic [7:0]  bank_open, pre_mask;
  logic [63:0] note;
  logic [63:0] iq[$];
  logic [63:0] pq[$];
  int          bad_count = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          pulses = 0;
  int          p0;
  int          seed = 32'hacf0c388;
  // core clock, and a link clock that stands low while stopped
  always #5 clk = ~clk;
  initial begin
    #3;
    forever #32 if (ck_run || ck) ck = ~ck;
  end
  ddr2_ctrl_model ddr2_ctrl_model_inst (
    .ck    (ck),
    .cke   (cke),
    .cs_n  (cs_n),
    .ras_n (ras_n),
    .cas_n (cas_n),
    .we_n  (we_n),
    .ba    (ba),
    .addr  (addr),
    .odt   (odt)
  );
  ddr2_command_function_logic #(.REFI_CYC(20))
    ddr2_command_function_logic_inst (
    .clk           (clk),
    .reset         (reset),
    .ck            (ck),
    .cke           (cke),
    .cs_n          (cs_n),
    .ras_n         (ras_n),
    .cas_n         (cas_n),
    .we_n          (we_n),
    .ba            (ba),
    .addr          (addr),
    .odt           (odt),
    .al            (al),
    .cl            (cl),
    .wr            (wr),
    .bl8           (bl8),
    .rtt_nom       (rtt_nom),
    .odt_on        (odt_on),
    .bank_open     (bank_open),
    .pre_mask      (pre_mask),
    .self_refresh  (self_refresh),
    .issue_valid   (issue_valid),
    .issue_write   (issue_write),
    .issue_bank    (issue_bank),
    .issue_row     (issue_row),
    .issue_col     (issue_col),
    .refresh_pulse (refresh_pulse),
    .refresh_row   (refresh_row),
    .dll_enable    (dll_enable)
  );
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // open a bank, then a column command on the very next edge
  task automatic access(input logic [2:0] b, input logic w, input logic ap);
    logic [13:0] r;
    logic [9:0]  c;
    int          due;
    r = 14'($random(seed));
    c = 10'($random(seed));
    ddr2_ctrl_model_inst.cmd(4'h3, b, r, 1'b1);
    ddr2_ctrl_model_inst.cmd({3'h2, ~w}, b, {3'h0, ap, c}, 1'b1);
    due = cyc + 3 + ((al > 3'h6) ? 6 : int'(al));
    iq.push_back({32'(due), 4'h0, w, b, r, c});
    due += (bl8 ? 4 : 2) + (w ? int'(cl) - 1 + int'(wr) : 0);
    if (ap) pq.push_back({32'(due), 24'h0, 8'h01 << b});
  endtask
  // results against the oldest notes, arrival cycle included
  always @(posedge ck) begin
    cyc <= cyc + 1;
    if (issue_valid !== 1'b0) begin
      note = iq.size() > 0 ? iq.pop_front() : {64{1'bx}};
      check("issue cycle", cyc, note[63:32]);
      check("issue", {4'h0, issue_write, issue_bank, issue_row, issue_col},
            note[31:0]);
    end
    if (pre_mask !== 8'h00) begin
      note = pq.size() > 0 ? pq.pop_front() : {64{1'bx}};
      check("precharge cycle", cyc, note[63:32]);
      check("precharge mask", {24'h0, pre_mask}, note[31:0]);
    end
  end
  always @(posedge clk) if (refresh_pulse === 1'b1) pulses <= pulses + 1;
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    ddr2_ctrl_model_inst.idle(40);
    check("banks at reset", {24'h0, bank_open}, 32'h0);
    check("dll at reset", {31'h0, dll_enable}, 32'h1);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      al <= 3'(i);
      bl8 <= i[0];
      cl <= 3'h3 + 3'(i % 3);
      wr <= 3'h2 + 3'(i % 4);
      ddr2_ctrl_model_inst.idle(2);
      access(3'($random(seed)), i[1], 1'b1);
      ddr2_ctrl_model_inst.idle(40);
      check("bank closed", {24'h0, bank_open}, 32'h0);
    end
    $display("test posted access done");
    access(3'h5, 1'b0, 1'b0);
    ddr2_ctrl_model_inst.idle(20);
    check("row kept open", {31'h0, bank_open[5]}, 32'h1);
    access(3'h1, 1'b0, 1'b0);
    ddr2_ctrl_model_inst.idle(10);
    ddr2_ctrl_model_inst.cmd(4'h2, 3'h1, 14'h0000, 1'b1);
    pq.push_back({32'(cyc + 3), 32'h02});
    ddr2_ctrl_model_inst.idle(4);
    check("bank precharged", {24'h0, bank_open}, 32'h20);
    ddr2_ctrl_model_inst.cmd(4'h2, 3'h6, 14'h0400, 1'b1);
    pq.push_back({32'(cyc + 3), 32'hff});
    ddr2_ctrl_model_inst.idle(10);
    check("all idle", {24'h0, bank_open}, 32'h0);
    $display("test precharge all done");
    for (int i = 0; i < 4; i++) begin
      ddr2_ctrl_model_inst.cmd(4'h0, 3'h1, {7'h0, i[1], 3'h0, i[0], 2'h0},
                               1'b1);
      ddr2_ctrl_model_inst.idle(8);
      check("termination", {30'h0, rtt_nom}, 32'(i));
    end
    $display("test termination done");
    access(3'h2, 1'b1, 1'b0);
    ddr2_ctrl_model_inst.idle(20);
    r0 = refresh_row;
    p0 = pulses;
    ddr2_ctrl_model_inst.cmd(4'h1, 3'h0, 14'h0000, 1'b1);
    ddr2_ctrl_model_inst.idle(20);
    check("refresh row", {18'h0, refresh_row}, {18'h0, r0 + 14'h1});
    check("refresh pulse", pulses - p0, 32'h1);
    check("banks refreshed", {24'h0, bank_open}, 32'h0);
    $display("test auto refresh done");
    p0 = pulses;
    ddr2_ctrl_model_inst.cmd(4'h1, 3'h0, 14'h0000, 1'b0);
    ddr2_ctrl_model_inst.idle(3);
    check("self refresh", {31'h0, self_refresh}, 32'h1);
    ck_run = 1'b0;
    repeat (70) @(posedge clk);
    check("dll off", {31'h0, dll_enable}, 32'h0);
    check("own timer", {31'h0, 1'(pulses - p0 >= 2)}, 32'h1);
    ck_run = 1'b1;
    ddr2_ctrl_model_inst.idle(4);
    ddr2_ctrl_model_inst.wake();
    ddr2_ctrl_model_inst.cmd(4'h3, 3'h4, 14'h1555, 1'b1);
    ddr2_ctrl_model_inst.idle(30);
    check("exit refused", {24'h0, bank_open}, 32'h0);
    check("awake", {30'h0, self_refresh, dll_enable}, 32'h1);
    p0 = pulses;
    ddr2_ctrl_model_inst.cmd(4'h1, 3'h0, 14'h0000, 1'b1);
    ddr2_ctrl_model_inst.idle(20);
    check("refresh after exit", pulses - p0, 32'h1);
    check("notes drained", 32'(iq.size() + pq.size()), 32'h0);
    $display("test self refresh done");
    conclude();
  end
  // cut a hang short well beyond the expected run length
  initial begin
    #400000;
    bad_count++;
    conclude();
  end
endmodule
`default_nettype wire

// file: hw/ddr2_command_function_logic.sv
// ddr2 device command decode, bank state, posted cas and self refresh
`timescale 1ns/1ps
`default_nettype none
`include "ddr2_cmd_params.svh"
module ddr2_command_function_logic #(
  parameter int REFI_CYC = `DDR2_TREFI_CYC
) (
  // core clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // command pins, sampled on the link clock
  input  wire logic        ck,
  input  wire logic        cke,
  input  wire logic        cs_n,
  input  wire logic        ras_n,
  input  wire logic        cas_n,
  input  wire logic        we_n,
  input  wire logic [2:0]  ba,
  input  wire logic [13:0] addr,
  input  wire logic        odt,
  // static configuration
  input  wire logic [2:0]  al,
  input  wire logic [2:0]  cl,
  input  wire logic [2:0]  wr,
  input  wire logic        bl8,
  // link-domain results
  output logic [1:0]       rtt_nom,
  output logic             odt_on,
  output logic [7:0]       bank_open,
  output logic [7:0]       pre_mask,
  output logic             self_refresh,
  output logic             issue_valid,
  output logic             issue_write,
  output logic [2:0]       issue_bank,
  output logic [13:0]      issue_row,
  output logic [9:0]       issue_col,
  // core-domain results
  output logic             refresh_pulse,
  output logic [13:0]      refresh_row,
  output logic             dll_enable
);
  ddr2_xing_if xing ();

  logic                        lrst_s1, lrst;
  logic                        cke_q, cs_n_q, ras_n_q, cas_n_q, we_n_q;
  logic                        odt_q;
  logic [2:0]                  ba_q;
  logic [13:0]                 addr_q;
  ddr2_cmd_pkg::cmd_t          cmd;
  ddr2_cmd_pkg::link_state_t   state, next_state;
  logic [7:0]                  xs_cnt, next_xs_cnt;
  logic                        next_sr, ref_tgl, next_ref_tgl;
  logic [13:0]                 rows [8];
  logic [13:0]                 next_rows [8];
  logic [7:0]                  next_open, pre_now, ap_fire;
  ddr2_cmd_pkg::rdwr_t         cur, sel;
  ddr2_cmd_pkg::rdwr_t         pipe [1:6];
  ddr2_cmd_pkg::rdwr_t         next_pipe [1:6];
  logic [2:0]                  al_eff;
  logic [4:0]                  rd_ap_len, wr_ap_len;
  logic [1:0]                  rtt_pend, next_pend, next_rtt;
  logic [3:0]                  tmod_cnt, next_tmod;

  // command decode from the registered pins
  function automatic ddr2_cmd_pkg::cmd_t decode_cmd(
    input logic       cke_l,
    input logic       cs,
    input logic [2:0] rcw,
    input logic       a10,
    input logic [2:0] bank
  );
    decode_cmd = ddr2_cmd_pkg::CMD_NOP;
    if (!cs) begin
      case (rcw)
        3'h3: decode_cmd = ddr2_cmd_pkg::CMD_ACT;
        3'h5: decode_cmd = ddr2_cmd_pkg::CMD_RD;
        3'h4: decode_cmd = ddr2_cmd_pkg::CMD_WR;
        3'h2: decode_cmd = a10 ? ddr2_cmd_pkg::CMD_PREA
                               : ddr2_cmd_pkg::CMD_PRE;
        3'h1: decode_cmd = cke_l ? ddr2_cmd_pkg::CMD_REF
                                 : ddr2_cmd_pkg::CMD_SRE;
        3'h0: decode_cmd = (bank == `DDR2_BA_EMR1) ?
                           ddr2_cmd_pkg::CMD_EMR1 :
                           ddr2_cmd_pkg::CMD_NOP;
        default: decode_cmd = ddr2_cmd_pkg::CMD_NOP;
      endcase
    end
  endfunction

  // one-hot bank mask
  function automatic logic [7:0] bank_bit(input logic [2:0] b);
    bank_bit = 8'h01 << b;
  endfunction

  // link-domain reset release, asserted at once
  always_ff @(posedge ck or posedge reset) begin
    if (reset) begin
      lrst_s1 <= 1'b1;
      lrst    <= 1'b1;
    end else begin
      lrst_s1 <= 1'b0;
      lrst    <= lrst_s1;
    end
  end

  // command pin input register
  always_ff @(posedge ck or posedge lrst) begin
    if (lrst) begin
      cke_q   <= 1'b0;
      cs_n_q  <= 1'b1;
      ras_n_q <= 1'b1;
      cas_n_q <= 1'b1;
      we_n_q  <= 1'b1;
      odt_q   <= 1'b0;
      ba_q    <= 3'h0;
      addr_q  <= 14'h0000;
    end else begin
      cke_q   <= cke;
      cs_n_q  <= cs_n;
      ras_n_q <= ras_n;
      cas_n_q <= cas_n;
      we_n_q  <= we_n;
      odt_q   <= odt;
      ba_q    <= ba;
      addr_q  <= addr;
    end
  end

  // commands are honoured only in normal operation
  always_comb begin
    cmd = ddr2_cmd_pkg::CMD_NOP;
    if (state == ddr2_cmd_pkg::ST_NORMAL) begin
      cmd = decode_cmd(cke_q, cs_n_q, {ras_n_q, cas_n_q, we_n_q},
                       addr_q[`DDR2_ADDR_AP], ba_q);
    end
  end

  // self refresh state machine and refresh event toggle
  always_comb begin
    next_state   = state;
    next_xs_cnt  = xs_cnt;
    next_sr      = self_refresh;
    next_ref_tgl = ref_tgl;
    case (state)
      ddr2_cmd_pkg::ST_NORMAL: begin
        if (cmd == ddr2_cmd_pkg::CMD_SRE) begin
          next_state = ddr2_cmd_pkg::ST_SELF_REF;
          next_sr    = 1'b1;
        end
        if (cmd == ddr2_cmd_pkg::CMD_REF) begin
          next_ref_tgl = ~ref_tgl;
        end
      end
      ddr2_cmd_pkg::ST_SELF_REF: begin
        if (cke_q) begin
          next_state  = ddr2_cmd_pkg::ST_SR_EXIT;
          next_xs_cnt = 8'(`DDR2_TXSNR_CYC - 1);
          next_sr     = 1'b0;
        end
      end
      ddr2_cmd_pkg::ST_SR_EXIT: begin
        if (xs_cnt == 8'h00) begin
          next_state = ddr2_cmd_pkg::ST_NORMAL;
        end else begin
          next_xs_cnt = xs_cnt - 8'h01;
        end
      end
      default: begin
        next_state = ddr2_cmd_pkg::ST_NORMAL;
        next_sr    = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ck or posedge lrst) begin
    if (lrst) begin
      state        <= ddr2_cmd_pkg::ST_NORMAL;
      xs_cnt       <= 8'h00;
      self_refresh <= 1'b0;
      ref_tgl      <= 1'b0;
    end else begin
      state        <= next_state;
      xs_cnt       <= next_xs_cnt;
      self_refresh <= next_sr;
      ref_tgl      <= next_ref_tgl;
    end
  end

  assign xing.sr_req  = self_refresh;
  assign xing.ref_tgl = ref_tgl;

  // column command entering the posted cas pipe
  always_comb begin
    cur.valid = (cmd == ddr2_cmd_pkg::CMD_RD) ||
                (cmd == ddr2_cmd_pkg::CMD_WR);
    cur.write = (cmd == ddr2_cmd_pkg::CMD_WR);
    cur.ap    = addr_q[`DDR2_ADDR_AP];
    cur.bank  = ba_q;
    cur.col   = addr_q[9:0];
  end

  // additive latency select, reserved codes held at the maximum
  assign al_eff = (al > `DDR2_AL_MAX) ? `DDR2_AL_MAX : al;
  assign rd_ap_len = 5'(al_eff) + (bl8 ? 5'h4 : 5'h2);
  assign wr_ap_len = 5'(al_eff) + 5'(cl) - 5'h1 +
                     (bl8 ? 5'h4 : 5'h2) + 5'(wr);

  // posted cas delay line and issue select
  always_comb begin
    next_pipe[1] = cur;
    for (int i = 2; i <= 6; i++) begin
      next_pipe[i] = pipe[i - 1];
    end
    sel = (al_eff == 3'h0) ? cur : pipe[al_eff];
  end

  always_ff @(posedge ck or posedge lrst) begin
    if (lrst) begin
      for (int i = 1; i <= 6; i++) begin
        pipe[i] <= '0;
      end
      issue_valid <= 1'b0;
      issue_write <= 1'b0;
      issue_bank  <= 3'h0;
      issue_row   <= 14'h0000;
      issue_col   <= 10'h000;
    end else begin
      pipe        <= next_pipe;
      issue_valid <= sel.valid;
      issue_write <= sel.write;
      issue_bank  <= sel.bank;
      issue_row   <= rows[sel.bank];
      issue_col   <= sel.col;
    end
  end

  // per-bank auto-precharge countdown
  for (genvar b = 0; b < `DDR2_BANKS; b++) begin : g_ap
    logic [4:0] cnt, next_cnt;
    always_comb begin
      next_cnt = cnt;
      if (cnt != 5'h00) begin
        next_cnt = cnt - 5'h01;
      end
      if (cur.valid && cur.ap && cur.bank == 3'(b)) begin
        next_cnt = cur.write ? wr_ap_len : rd_ap_len;
      end
    end
    always_ff @(posedge ck or posedge lrst) begin
      if (lrst) begin
        cnt <= 5'h00;
      end else begin
        cnt <= next_cnt;
      end
    end
    assign ap_fire[b] = (cnt == 5'h01);
  end

  // bank open state and open row per bank
  always_comb begin
    pre_now = ap_fire;
    if (cmd == ddr2_cmd_pkg::CMD_PREA) begin
      pre_now = 8'hff;
    end else if (cmd == ddr2_cmd_pkg::CMD_PRE) begin
      pre_now = pre_now | bank_bit(ba_q);
    end
    next_open = bank_open & ~pre_now;
    next_rows = rows;
    if (cmd == ddr2_cmd_pkg::CMD_ACT) begin
      next_open      = next_open | bank_bit(ba_q);
      next_rows[ba_q] = addr_q;
    end
    if (cmd == ddr2_cmd_pkg::CMD_REF) begin
      next_open = 8'h00;
    end
  end

  always_ff @(posedge ck or posedge lrst) begin
    if (lrst) begin
      bank_open <= 8'h00;
      pre_mask  <= 8'h00;
      for (int i = 0; i < 8; i++) begin
        rows[i] <= 14'h0000;
      end
    end else begin
      bank_open <= next_open;
      pre_mask  <= pre_now;
      rows      <= next_rows;
    end
  end

  // termination value update after tMOD minimum
  always_comb begin
    next_pend = rtt_pend;
    next_tmod = tmod_cnt;
    next_rtt  = rtt_nom;
    if (tmod_cnt != 4'h0) begin
      next_tmod = tmod_cnt - 4'h1;
      if (tmod_cnt == 4'h1) begin
        next_rtt = rtt_pend;
      end
    end
    if (cmd == ddr2_cmd_pkg::CMD_EMR1) begin
      next_pend = {addr_q[`DDR2_RTT_HI], addr_q[`DDR2_RTT_LO]};
      next_tmod = 4'(`DDR2_TMOD_MIN_CYC);
    end
  end

  always_ff @(posedge ck or posedge lrst) begin
    if (lrst) begin
      rtt_pend <= 2'h0;
      tmod_cnt <= 4'h0;
      rtt_nom  <= 2'h0;
      odt_on   <= 1'b0;
    end else begin
      rtt_pend <= next_pend;
      tmod_cnt <= next_tmod;
      rtt_nom  <= next_rtt;
      odt_on   <= odt_q && (state == ddr2_cmd_pkg::ST_NORMAL);
    end
  end

  // core-domain refresh engine
  ddr2_refresh_core #(
    .REFI_CYC (REFI_CYC)
  ) u_refresh (
    .clk           (clk),
    .reset         (reset),
    .xing          (xing.core),
    .refresh_pulse (refresh_pulse),
    .refresh_row   (refresh_row),
    .dll_enable    (dll_enable)
  );
endmodule
`default_nettype wire

// file: hw/ddr2_refresh_core.sv
// core-domain refresh engine: self refresh timer and refresh row counter
`timescale 1ns/1ps
`default_nettype none
`include "ddr2_cmd_params.svh"
module ddr2_refresh_core #(
  parameter int REFI_CYC = `DDR2_TREFI_CYC
) (
  // core clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // from the link domain
  ddr2_xing_if.core        xing,
  // refresh results
  output logic             refresh_pulse,
  output logic [13:0]      refresh_row,
  output logic             dll_enable
);
  logic        sr_s1, sr_s2;
  logic        tg_s1, tg_s2, tg_s3;
  logic [11:0] timer, next_timer;
  logic        next_pulse;
  logic [13:0] next_row;

  // next refresh state: own timer in self refresh, events otherwise
  always_comb begin
    next_pulse = 1'b0;
    next_timer = 12'(REFI_CYC - 1);
    next_row   = refresh_row;
    if (sr_s2) begin
      next_timer = timer - 12'h001;
      if (timer == 12'h000) begin
        next_pulse = 1'b1;
        next_timer = 12'(REFI_CYC - 1);
      end
    end
    if (tg_s2 ^ tg_s3) begin
      next_pulse = 1'b1;
    end
    if (next_pulse) begin
      next_row = refresh_row + 14'h0001;
    end
  end

  // synchronisers and refresh registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sr_s1         <= 1'b0;
      sr_s2         <= 1'b0;
      tg_s1         <= 1'b0;
      tg_s2         <= 1'b0;
      tg_s3         <= 1'b0;
      timer         <= 12'h000;
      refresh_pulse <= 1'b0;
      refresh_row   <= 14'h0000;
      dll_enable    <= 1'b0;
    end else begin
      sr_s1         <= xing.sr_req;
      sr_s2         <= sr_s1;
      tg_s1         <= xing.ref_tgl;
      tg_s2         <= tg_s1;
      tg_s3         <= tg_s2;
      timer         <= next_timer;
      refresh_pulse <= next_pulse;
      refresh_row   <= next_row;
      dll_enable    <= ~sr_s2;
    end
  end
endmodule
`default_nettype wire

// file: shared/ddr2_cmd_params.svh
// timing counts, field positions and limits of the command logic
`ifndef DDR2_CMD_PARAMS_SVH
`define DDR2_CMD_PARAMS_SVH
`define DDR2_CLK_NS       10
`define DDR2_TMOD_MIN_NS  12
`define DDR2_TMOD_MIN_CYC \
  ((`DDR2_TMOD_MIN_NS + `DDR2_CLK_NS - 1) / `DDR2_CLK_NS)
`define DDR2_TXSNR_NS     140
`define DDR2_TXSNR_CYC \
  ((`DDR2_TXSNR_NS + `DDR2_CLK_NS - 1) / `DDR2_CLK_NS)
`define DDR2_TREFI_NS     7800
`define DDR2_TREFI_CYC    (`DDR2_TREFI_NS / `DDR2_CLK_NS)
`define DDR2_AL_MAX       3'h6
`define DDR2_ADDR_AP      10
`define DDR2_RTT_HI       6
`define DDR2_RTT_LO       2
`define DDR2_BA_EMR1      3'h1
`define DDR2_BANKS        8
`endif

// file: shared/ddr2_cmd_pkg.sv
// types shared by the command logic
`default_nettype none
package ddr2_cmd_pkg;
  typedef enum logic [2:0] {
    ST_NORMAL   = 3'h1,
    ST_SELF_REF = 3'h2,
    ST_SR_EXIT  = 3'h4
  } link_state_t;
  typedef enum logic [3:0] {
    CMD_NOP  = 4'h0,
    CMD_ACT  = 4'h1,
    CMD_RD   = 4'h2,
    CMD_WR   = 4'h3,
    CMD_PRE  = 4'h4,
    CMD_PREA = 4'h5,
    CMD_REF  = 4'h6,
    CMD_SRE  = 4'h7,
    CMD_EMR1 = 4'h8
  } cmd_t;
  typedef struct packed {
    logic       valid;
    logic       write;
    logic       ap;
    logic [2:0] bank;
    logic [9:0] col;
  } rdwr_t;
endpackage
`default_nettype wire

// file: shared/ddr2_xing_if.sv
// signals crossing from the link domain into the core domain
`timescale 1ns/1ps
`default_nettype none
interface ddr2_xing_if;
  logic sr_req;   // level: device is in self refresh
  logic ref_tgl;  // toggles once per auto refresh command
  modport link (output sr_req, output ref_tgl);
  modport core (input sr_req, input ref_tgl);
endinterface
`default_nettype wire
